// ### ccseq_map.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef CCSEQ_MAP_SVH
`define CCSEQ_MAP_SVH

// ==========================================================================
// register offsets (4-bit address)
`define CCSEQ_ADDR_CTRL 4'h0
`define CCSEQ_ADDR_STAT 4'h1
`define CCSEQ_ADDR_IRQ 4'h2
`define CCSEQ_ADDR_MASK 4'h3
`define CCSEQ_ADDR_TIMER 4'h4

// ==========================================================================
// ctrl fields
`define CCSEQ_CTRL_SOFT_EN 0
`define CCSEQ_CTRL_RST 8'h01

// ==========================================================================
// event bits of irq status and mask
`define CCSEQ_EV_NEWCYC 0
`define CCSEQ_EV_EOC 1
`define CCSEQ_EV_FAULT 2
`define CCSEQ_EV_SLEEP 3
`define CCSEQ_EV_W 4
`define CCSEQ_MASK_RST 4'h0

// ==========================================================================
// timing
`define CCSEQ_TIMER_W 22
// nominal tick period in ns (3 ms) and its cycles at 4 ns per clock
`define CCSEQ_TICK_PERIOD_NS 3000000
`define CCSEQ_CLK_PERIOD_NS 4
`define CCSEQ_TICK_CYC (`CCSEQ_TICK_PERIOD_NS / `CCSEQ_CLK_PERIOD_NS)
// trickle limit is one eighth of the full timeout
`define CCSEQ_TRICKLE_SHIFT 3

`endif

// ### ccseq_pkg.sv
// types shared by the charge cycle sequencer
package ccseq_pkg;

   // ========================================================================
   // phases
   typedef enum logic [2:0] {
      PH_SLEEP,
      PH_STANDBY,
      PH_TRICKLE,
      PH_CC,
      PH_CV,
      PH_DONE,
      PH_FAULT
   } ccseq_phase_t;

   // ========================================================================
   // comparator outcomes, all from the analog side
   typedef struct packed {
      logic supply_ok;
      logic above_trickle_exit;
      logic at_regulation;
      logic below_recharge;
      logic eoc_current;
   } ccseq_cmp_t;

   // ========================================================================
   // charger drive controls
   typedef struct packed {
      logic bias_rail_output;
      logic osc_run;
      logic charge_on;
      logic precharge_current;
      logic volt_reg;
   } ccseq_drive_t;

endpackage : ccseq_pkg

// ### ccseq_sync.sv
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module ccseq_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : ccseq_sync

// ### ccseq_top.sv
// charge cycle sequencer: phases, safety timer, status and register port
// ==========================================================================
`timescale 1ns/1ps
`include "ccseq_map.svh"
module ccseq_top #(
   parameter int TIMER_W = `CCSEQ_TIMER_W,
   parameter int TICK_CYC = `CCSEQ_TICK_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pins and comparators, asynchronous
   input wire logic enable_i,
   input wire ccseq_pkg::ccseq_cmp_t cmp_i,
   // charger controls and status pin
   output ccseq_pkg::ccseq_drive_t drive_o,
   output logic status_o,
   output logic status_oe_o,
   output ccseq_pkg::ccseq_phase_t phase_o,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // interrupt
   output logic irq_o
);
   // =======================================================================
   // input synchronisation
   logic en_s;
   ccseq_pkg::ccseq_cmp_t cmp_s;

   ccseq_sync #(.W(6)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({enable_i, cmp_i}),
      .q_o({en_s, cmp_s})
   );

   // =======================================================================
   // qualifiers
   logic en_d_r;
   logic pwr_d_r;
   logic [7:0] ctrl_r;
   logic enabled;
   logic en_rise;
   logic pwr_rise;
   logic restart;

   assign enabled = en_s & ctrl_r[`CCSEQ_CTRL_SOFT_EN];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_d_r <= 1'b0;
         pwr_d_r <= 1'b0;
      end else begin
         en_d_r <= enabled;
         pwr_d_r <= cmp_s.supply_ok;
      end
   end
   assign en_rise = enabled & ~en_d_r;
   assign pwr_rise = cmp_s.supply_ok & ~pwr_d_r;
   // either start clears divider, timer and eoc latch in the same cycle
   assign restart = en_rise | pwr_rise;

   // =======================================================================
   // tick divider and safety timer
   ccseq_pkg::ccseq_phase_t phase_r;
   ccseq_pkg::ccseq_phase_t phase_nxt;
   logic [31:0] div_r;
   logic tick;
   logic [TIMER_W-1:0] timer_r;
   logic timer_full;
   logic trickle_lim;
   logic charging;

   assign charging = (phase_r == ccseq_pkg::PH_TRICKLE) |
                     (phase_r == ccseq_pkg::PH_CC) |
                     (phase_r == ccseq_pkg::PH_CV);
   assign tick = (div_r == 32'(TICK_CYC - 1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= 32'h0;
      end else if (restart || !charging || tick) begin
         div_r <= 32'h0;
      end else begin
         div_r <= div_r + 32'h1;
      end
   end

   // timer counts through trickle, cc and cv; one count wraps the full scale
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_r <= '0;
      end else if (restart || phase_nxt == ccseq_pkg::PH_STANDBY) begin
         timer_r <= '0;
      end else if (charging && tick) begin
         timer_r <= timer_r + 1'b1;
      end
   end
   assign timer_full = charging & tick & (&timer_r);
   assign trickle_lim = (timer_r >= TIMER_W'(1 << (TIMER_W -
                        `CCSEQ_TRICKLE_SHIFT)));

   // =======================================================================
   // end-of-charge indication latch
   logic eoc_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eoc_r <= 1'b0;
      end else if (restart || phase_r == ccseq_pkg::PH_STANDBY) begin
         eoc_r <= 1'b0;
      end else if (phase_r == ccseq_pkg::PH_CV && cmp_s.eoc_current) begin
         eoc_r <= 1'b1;
      end
   end

   // =======================================================================
   // phase sequencer
   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         ccseq_pkg::PH_SLEEP: begin
            if (cmp_s.supply_ok) begin
               phase_nxt = ccseq_pkg::PH_STANDBY;
            end
         end
         ccseq_pkg::PH_STANDBY: begin
            if (enabled) begin
               phase_nxt = ccseq_pkg::PH_TRICKLE;
            end
         end
         ccseq_pkg::PH_TRICKLE: begin
            if (trickle_lim) begin
               phase_nxt = ccseq_pkg::PH_FAULT;
            end else if (cmp_s.above_trickle_exit) begin
               phase_nxt = ccseq_pkg::PH_CC;
            end
         end
         ccseq_pkg::PH_CC: begin
            if (timer_full) begin
               phase_nxt = ccseq_pkg::PH_FAULT;
            end else if (cmp_s.at_regulation) begin
               phase_nxt = ccseq_pkg::PH_CV;
            end
         end
         ccseq_pkg::PH_CV: begin
            if (timer_full) begin
               // charging stops at the timeout whether or not eoc was seen
               phase_nxt = eoc_r ? ccseq_pkg::PH_DONE
                                 : ccseq_pkg::PH_FAULT;
            end
         end
         ccseq_pkg::PH_DONE: begin
            if (cmp_s.below_recharge) begin
               phase_nxt = ccseq_pkg::PH_STANDBY;
            end
         end
         ccseq_pkg::PH_FAULT: begin
            phase_nxt = ccseq_pkg::PH_FAULT;
         end
         default: begin
            phase_nxt = ccseq_pkg::PH_SLEEP;
         end
      endcase
      // disable returns any charged phase to standby and clears a fault; enable rise restarts from standby
      if (en_rise && cmp_s.supply_ok) begin
         phase_nxt = ccseq_pkg::PH_STANDBY;
      end
      if (!enabled && cmp_s.supply_ok) begin
         phase_nxt = ccseq_pkg::PH_STANDBY;
      end
      if (!cmp_s.supply_ok) begin
         phase_nxt = ccseq_pkg::PH_SLEEP;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_r <= ccseq_pkg::PH_SLEEP;
      end else begin
         phase_r <= phase_nxt;
      end
   end
   assign phase_o = phase_r;

   // =======================================================================
   // drive outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drive_o <= '0;
         status_oe_o <= 1'b0;
      end else begin
         drive_o.bias_rail_output <= (phase_nxt != ccseq_pkg::PH_SLEEP);
         drive_o.osc_run <= (phase_nxt != ccseq_pkg::PH_SLEEP);
         drive_o.charge_on <= (phase_nxt == ccseq_pkg::PH_TRICKLE) |
                              (phase_nxt == ccseq_pkg::PH_CC) |
                              (phase_nxt == ccseq_pkg::PH_CV);
         drive_o.precharge_current <=
            (phase_nxt == ccseq_pkg::PH_TRICKLE);
         drive_o.volt_reg <= (phase_nxt == ccseq_pkg::PH_CV);
         // released once eoc is seen even though current still flows
         status_oe_o <= ((phase_nxt == ccseq_pkg::PH_TRICKLE) |
                         (phase_nxt == ccseq_pkg::PH_CC) |
                         (phase_nxt == ccseq_pkg::PH_CV)) &
                        ~(eoc_r & phase_nxt == ccseq_pkg::PH_CV);
      end
   end
   assign status_o = 1'b0; // open drain: only ever pulls low

   // =======================================================================
   // events and interrupt
   logic [`CCSEQ_EV_W-1:0] ev;
   logic [`CCSEQ_EV_W-1:0] irq_r;
   logic [`CCSEQ_EV_W-1:0] mask_r;
   logic irq_rd;

   assign ev[`CCSEQ_EV_NEWCYC] = (phase_nxt == ccseq_pkg::PH_TRICKLE) &
                                 (phase_r != ccseq_pkg::PH_TRICKLE);
   assign ev[`CCSEQ_EV_EOC] = (phase_r == ccseq_pkg::PH_CV) &
                              cmp_s.eoc_current & ~eoc_r;
   assign ev[`CCSEQ_EV_FAULT] = (phase_nxt == ccseq_pkg::PH_FAULT) &
                                (phase_r != ccseq_pkg::PH_FAULT);
   assign ev[`CCSEQ_EV_SLEEP] = (phase_nxt == ccseq_pkg::PH_SLEEP) &
                                (phase_r != ccseq_pkg::PH_SLEEP);
   assign irq_rd = rd_i & (addr_i == `CCSEQ_ADDR_IRQ);

   // a new event wins over the read that clears
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_r <= '0;
      end else begin
         irq_r <= (irq_rd ? '0 : irq_r) | ev;
      end
   end
   assign irq_o = |(irq_r & mask_r);

   // =======================================================================
   // register port
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `CCSEQ_CTRL_RST;
         mask_r <= `CCSEQ_MASK_RST;
      end else if (wr_i) begin
         if (addr_i == `CCSEQ_ADDR_CTRL) begin
            ctrl_r <= {7'h00, wdata_i[`CCSEQ_CTRL_SOFT_EN]};
         end
         if (addr_i == `CCSEQ_ADDR_MASK) begin
            mask_r <= wdata_i[`CCSEQ_EV_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            `CCSEQ_ADDR_CTRL: rdata_o <= ctrl_r;
            `CCSEQ_ADDR_STAT: rdata_o <= {3'h0, eoc_r, 1'b0, phase_r};
            `CCSEQ_ADDR_IRQ: rdata_o <= {4'h0, irq_r};
            `CCSEQ_ADDR_MASK: rdata_o <= {4'h0, mask_r};
            `CCSEQ_ADDR_TIMER: rdata_o <= timer_r[TIMER_W-1 -: 8];
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule : ccseq_top

// ### ccseq_checker.sv
// port assertions of the charge cycle sequencer
`timescale 1ns/1ps
module ccseq_checker #(
   parameter int TIMER_W = 22,
   parameter int TICK_CYC = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pins
   input wire logic enable_i,
   input wire ccseq_pkg::ccseq_cmp_t cmp_i,
   input wire ccseq_pkg::ccseq_drive_t drive_o,
   input wire logic status_o,
   input wire logic status_oe_o,
   input wire ccseq_pkg::ccseq_phase_t phase_o,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o
);
   // ====
   // cycles spent in the running charge cycle
   // tick divider clears outside charging, yet limits allow one tick of slack
   localparam int TCK = 2 ** (TIMER_W - 3);
   localparam int TR_MIN = (TCK - 1) * TICK_CYC;
   localparam int TR_MAX = (TCK + 1) * TICK_CYC + 4;
   localparam int TO_MIN = (8 * TCK - 1) * TICK_CYC;
   localparam int TO_MAX = (8 * TCK + 1) * TICK_CYC + 4;
   logic chg;
   logic [31:0] cnt_r;
   assign chg = phase_o inside {ccseq_pkg::PH_TRICKLE, ccseq_pkg::PH_CC,
      ccseq_pkg::PH_CV};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 32'h0;
      end else begin
         cnt_r <= chg ? cnt_r + 32'h1 : 32'h0;
      end
   end
   // ====
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_reg_held;
      (phase_o == ccseq_pkg::PH_CC && cmp_i.at_regulation) [*5];
   endsequence
   sequence s_fault_held;
      (phase_o == ccseq_pkg::PH_FAULT && enable_i && cmp_i.supply_ok) [*6];
   endsequence
   a_cv_on_reg: assert property (s_reg_held |-> phase_o != ccseq_pkg::PH_CC)
      else $error("regulation level ignored");
   a_cv_entry: assert property (phase_o == ccseq_pkg::PH_CV &&
      $past(phase_o) != ccseq_pkg::PH_CV |-> $past(phase_o) == ccseq_pkg::PH_CC)
      else $error("regulation phase entered out of order");
   a_status_low: assert property (phase_o inside {ccseq_pkg::PH_TRICKLE,
      ccseq_pkg::PH_CC} |-> status_oe_o) else $error("status not pulled");
   a_status_rel: assert property (!chg |-> !status_oe_o && !status_o &&
      !drive_o.charge_on) else $error("idle phase still active");
   a_eoc_flag: assert property ((phase_o == ccseq_pkg::PH_CV &&
      cmp_i.eoc_current) [*5] |-> !status_oe_o && drive_o.charge_on)
      else $error("end of charge flag wrong");
   a_pre_cur: assert property (chg |-> drive_o.charge_on &&
      drive_o.precharge_current == (phase_o == ccseq_pkg::PH_TRICKLE))
      else $error("charge current kind wrong");
   a_sleep_quiet: assert property (phase_o == ccseq_pkg::PH_SLEEP |->
      drive_o == '0) else $error("sleep drives outputs");
   a_fault_src: assert property (phase_o == ccseq_pkg::PH_FAULT &&
      $past(phase_o) != ccseq_pkg::PH_FAULT |-> $past(chg))
      else $error("fault outside charging");
   a_fault_latch: assert property (s_fault_held |=>
      phase_o == ccseq_pkg::PH_FAULT) else $error("fault released");
   a_trickle_lim: assert property (phase_o == ccseq_pkg::PH_TRICKLE |->
      cnt_r <= TR_MAX) else $error("trickle overran its limit");
   a_trickle_min: assert property (phase_o == ccseq_pkg::PH_FAULT &&
      $past(phase_o) == ccseq_pkg::PH_TRICKLE |-> cnt_r >= TR_MIN)
      else $error("trickle fault too early");
   a_total_lim: assert property (chg |-> cnt_r <= TO_MAX)
      else $error("charging overran the timeout");
   a_done_time: assert property (phase_o == ccseq_pkg::PH_DONE &&
      $past(phase_o) == ccseq_pkg::PH_CV |-> cnt_r >= TO_MIN)
      else $error("charge ended before the timeout");
endmodule : ccseq_checker

bind ccseq_top ccseq_checker #(.TIMER_W(TIMER_W), .TICK_CYC(TICK_CYC)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .cmp_i(cmp_i),
   .drive_o(drive_o), .status_o(status_o), .status_oe_o(status_oe_o),
   .phase_o(phase_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ### ccseq_batt.sv
// battery model feeding the charge comparators
`timescale 1ns/1ps
module ccseq_batt (
   // clock
   input wire logic clk_i,
   // charger controls and bench knobs
   input wire ccseq_pkg::ccseq_drive_t drive_i,
   input wire logic supply_i,
   input wire logic hold_i,
   input wire logic drain_i,
   input wire logic dead_i,
   input wire logic eoc_en_i,
   // comparator outcomes
   output ccseq_pkg::ccseq_cmp_t cmp_o
);
   // ====
   // cell level: 16 trickle exit, 60 regulation, below 50 recharge
   int v = 0;
   int t = 0;
   always @(posedge clk_i) begin
      if (dead_i) begin
         v <= 0;
      end else if (drain_i && v > 0) begin
         v <= v - 1;
      end else if (drive_i.charge_on && !hold_i && v < 60) begin
         v <= v + 1;
      end
      // current tapers while held at regulation
      t <= (v >= 60 && drive_i.charge_on) ? t + 1 : 0;
   end
   assign cmp_o = {supply_i, v >= 16, v >= 60, v < 50, eoc_en_i && t > 20};
endmodule : ccseq_batt

// ### ccseq_test.sv
// self-checking bench of the charge cycle sequencer
`timescale 1ns/1ps
module ccseq_test;
   // ====
   // stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic enable_i = 1'b0;
   logic supply = 1'b0, hold = 1'b0, drain = 1'b0, dead = 1'b0;
   logic eoc_en = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
   ccseq_pkg::ccseq_cmp_t cmp;
   ccseq_pkg::ccseq_drive_t drv;
   ccseq_pkg::ccseq_phase_t ph;
   logic [7:0] rdata;
   logic irq, oe, st;
   logic [15:0] q[$];
   int error_cnt = 0, n_tests = 0, cyc = 0;
   int seed = 32'h46f4;
   logic [7:0] rnd;
   always #2 clk_i = ~clk_i;
   // short timer so a whole cycle fits in a few hundred clocks
   ccseq_top #(.TIMER_W(6), .TICK_CYC(8)) uut (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .enable_i(enable_i), .cmp_i(cmp), .drive_o(drv),
      .status_o(st), .status_oe_o(oe), .phase_o(ph), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
      .irq_o(irq));
   ccseq_batt batt (.clk_i(clk_i), .drive_i(drv), .supply_i(supply),
      .hold_i(hold), .drain_i(drain), .dead_i(dead), .eoc_en_i(eoc_en),
      .cmp_o(cmp));
   // ====
   // tasks
   task print_verdict;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   // note holds the mask in its upper byte, the masked value below
   task automatic chk(input logic [7:0] got, input logic [15:0] me);
      n_tests++;
      if ((got & me[15:8]) !== me[7:0]) begin
         error_cnt++;
         $display("Error %0t got %h exp %h", $time, got, me[7:0]);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] me);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      q.push_back(me);
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask : rd
   task automatic wait_ph(input ccseq_pkg::ccseq_phase_t p, input int n);
      for (int i = 0; i < n && ph !== p; i++) @(negedge clk_i);
      chk({5'h0, ph}, {8'h07, 5'h0, p});
      @(posedge clk_i);
   endtask : wait_ph
   // ====
   // read data stand only in the cycle after the strobe
   always @(posedge clk_i) rd_d <= rd_i;
   always @(negedge clk_i) if (rd_d) chk(rdata, q.pop_front());
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict;
      end
   end
   // ====
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rnd = $random(seed);
      rd(4'h0, 16'hFF01);
      wr(4'h3, {4'h0, rnd[3:0]});
      rd(4'h3, {8'h0F, 4'h0, rnd[3:0]});
      rd({1'b1, rnd[6:4]}, 16'hFF00);
      wr(4'h0, {rnd[7:1], 1'b1});
      rd(4'h0, 16'hFF01);
      wr(4'h3, 8'h01);
      supply <= 1'b1;
      wait_ph(ccseq_pkg::PH_STANDBY, 10);
      enable_i <= 1'b1;
      wait_ph(ccseq_pkg::PH_TRICKLE, 10);
      @(negedge clk_i);
      chk({7'h0, irq}, 16'h0101);
      rd(4'h2, 16'h0101);
      @(negedge clk_i);
      chk({7'h0, irq}, 16'h0100);
      wait_ph(ccseq_pkg::PH_CC, 100);
      wait_ph(ccseq_pkg::PH_CV, 200);
      wait_ph(ccseq_pkg::PH_DONE, 700);
      rd(4'h1, 16'h0705);
      drain <= 1'b1;
      wait_ph(ccseq_pkg::PH_TRICKLE, 200);
      drain <= 1'b0;
      enable_i <= 1'b0;
      wait_ph(ccseq_pkg::PH_STANDBY, 10);
      dead <= 1'b1;
      hold <= 1'b1;
      @(posedge clk_i);
      dead <= 1'b0;
      enable_i <= 1'b1;
      wait_ph(ccseq_pkg::PH_TRICKLE, 10);
      wait_ph(ccseq_pkg::PH_FAULT, 200);
      repeat (30) @(posedge clk_i);
      rd(4'h1, 16'h0706);
      rd(4'h2, 16'h0404);
      enable_i <= 1'b0;
      wait_ph(ccseq_pkg::PH_STANDBY, 10);
      enable_i <= 1'b1;
      wait_ph(ccseq_pkg::PH_TRICKLE, 10);
      hold <= 1'b0;
      eoc_en <= 1'b0;
      wait_ph(ccseq_pkg::PH_FAULT, 800);
      supply <= 1'b0;
      wait_ph(ccseq_pkg::PH_SLEEP, 10);
      rd(4'h2, 16'h0808);
      supply <= 1'b1;
      wait_ph(ccseq_pkg::PH_TRICKLE, 20);
      print_verdict;
   end
endmodule : ccseq_test
